/* rtl/cps_ctrl_pins.sv */
// control port pin logic: interface strap, shared spi/smbus target, swing, enable, lock pin
`timescale 1ns/100ps

module cps_ctrl_pins
  import cps_pkg::*;
#(
  parameter logic [6:0] ADDR_BASE = SMB_ADDR_BASE
) (
  input  wire logic               clock,
  input  wire logic               rst,
  input  wire logic [THERM_W-1:0] cable_drive_swing_select,
  input  wire logic [THERM_W-1:0] mode_select_level,
  input  wire logic               enable_pin,
  input  wire logic               enable_driven,
  input  wire logic [THERM_W-1:0] pin11_level,
  input  wire logic               pin11_in,
  input  wire logic               pin11_driven,
  input  wire logic               pin13_in,
  output logic                    pin13_out,
  output logic                    pin13_oe,
  input  wire logic [THERM_W-1:0] pin28_level,
  output logic                    pin28_out,
  output logic                    pin28_oe,
  input  wire logic               pin29_in,
  output logic                    pin29_out,
  output logic                    pin29_oe,
  input  wire logic               reclock_locked,
  input  wire logic               carrier_present,
  input  wire logic               irq_pending,
  input  wire logic [1:0]         lock_pin_func,
  output logic                    lock_out,
  output logic                    lock_oe,
  output logic [1:0]              bidir_coax_port_swing,
  output logic [1:0]              aux_coax_driver_swing,
  output logic                    power_down,
  output logic                    spi_active,
  output logic                    smbus_active,
  output logic [6:0]              bus_address,
  output logic [7:0]              reg_addr,
  output logic [7:0]              reg_wdata,
  output logic                    reg_wr,
  output logic                    reg_rd,
  input  wire logic [7:0]         reg_rdata
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // bubbles in the thermometer code are tolerated by counting ones
  function automatic logic [1:0] lvl_decode(input logic [THERM_W-1:0] t);
    logic [1:0] n;
    n = 2'h0;
    for (int i = 0; i < THERM_W; i++) begin
      n = n + {1'b0, t[i]};
    end
    return n;
  endfunction

  function automatic logic [6:0] smb_addr(input logic [3:0] idx);
    return 7'(ADDR_BASE + {3'h0, idx});
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [PIN_W-1:0] meta;
    logic [PIN_W-1:0] sync;
    logic             scl_d;
    logic             sda_d;
    logic [CNT_W-1:0] settle;
    logic             straps_done;
    cps_iface_t       iface;
    logic [3:0]       addr_idx;
    logic [1:0]       swing;
    logic             power_down;
    logic             lock_oe;
    cps_state_t       state;
    logic [7:0]       shreg;
    logic [4:0]       bitcnt;
    logic             rw;
    logic             have_ptr;
    logic             bump;
    logic             first_drive;
    logic             miso;
    logic             sda_oe;
    logic [7:0]       reg_addr;
    logic [7:0]       reg_wdata;
    logic             reg_wr;
    logic             reg_rd;
  } cps_regs_t;

  localparam cps_regs_t REGS_RESET = '{iface: IF_NONE, state: ST_IDLE, default: '0};

  cps_regs_t st;
  cps_regs_t next_st;

  logic [PIN_W-1:0] raw;
  logic             en;
  logic             ss_n;
  logic             spi_sel;
  logic             smb;
  logic             c;
  logic             sda;
  logic             rise;
  logic             fall;
  logic             start;
  logic             stop;
  logic             carrier_present_flag_low;

  assign raw = {pin29_in, pin13_in, pin11_driven, pin11_in, enable_driven, enable_pin,
                pin28_level, pin11_level, mode_select_level, cable_drive_swing_select};

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st        = st;
    next_st.meta   = raw;
    next_st.sync   = st.meta;
    next_st.reg_wr = 1'b0;
    next_st.reg_rd = 1'b0;

    en      = st.sync[P_EN] | ~st.sync[P_EN_DRV];
    ss_n    = st.sync[P_P11] | ~st.sync[P_P11_DRV];
    spi_sel = (st.iface == IF_SPI) && !ss_n;
    smb     = (st.iface == IF_SMB);
    c       = st.sync[P_P29];
    sda     = st.sync[P_P13];
    rise    = c & ~st.scl_d;
    fall    = ~c & st.scl_d;
    start   = smb & c & st.scl_d & st.sda_d & ~sda;
    stop    = smb & c & st.scl_d & ~st.sda_d & sda;
    next_st.scl_d = c;
    next_st.sda_d = sda;

    // straps are taken once, after the synchronisers have filled
    if (!st.straps_done) begin
      if (st.settle == CNT_W'(STRAP_WAIT_CYC - 1)) begin
        next_st.straps_done = 1'b1;
        next_st.addr_idx = {lvl_decode(st.sync[P_P28LVL +: THERM_W]),
                            lvl_decode(st.sync[P_P11LVL +: THERM_W])};
        if (lvl_decode(st.sync[P_MODE +: THERM_W]) == LVL_L) begin
          next_st.iface = IF_SMB;
        end else if (lvl_decode(st.sync[P_MODE +: THERM_W]) == LVL_F) begin
          next_st.iface = IF_SPI;
        end else begin
          next_st.iface = IF_NONE;
        end
      end else begin
        next_st.settle = CNT_W'(st.settle + 1'b1);
      end
    end

    next_st.swing      = lvl_decode(st.sync[P_SWING +: THERM_W]);
    next_st.power_down = ~en;

    carrier_present_flag_low = ~carrier_present;
    if (lock_pin_func == LOCK_FN_CARRIER) begin
      next_st.lock_oe = ~carrier_present_flag_low;
    end else if (lock_pin_func == LOCK_FN_IRQ) begin
      next_st.lock_oe = irq_pending;
    end else begin
      next_st.lock_oe = reclock_locked;
    end

    // read data is taken in the same cycle as the read strobe
    if (st.reg_rd) begin
      next_st.shreg = reg_rdata;
      if (st.state == ST_SPI) begin
        next_st.miso = reg_rdata[7];
      end else if (st.first_drive) begin
        next_st.sda_oe      = ~reg_rdata[7];
        next_st.shreg       = {reg_rdata[6:0], 1'b0};
        next_st.first_drive = 1'b0;
      end
    end

    if (start) begin
      next_st.state    = ST_ADDR;
      next_st.bitcnt   = 5'h00;
      next_st.sda_oe   = 1'b0;
      next_st.have_ptr = 1'b0; // a new transaction starts without a pointer
      next_st.bump     = 1'b0;
    end else if (stop) begin
      next_st.state  = ST_IDLE;
      next_st.sda_oe = 1'b0;
    end else begin
      case (st.state)
        ST_IDLE: begin
          if (spi_sel) begin
            next_st.state  = ST_SPI;
            next_st.bitcnt = 5'h00;
          end
        end
        ST_SPI: begin
          if (!spi_sel) begin
            next_st.state = ST_IDLE;
            next_st.miso  = 1'b0;
          end else if (rise && st.bitcnt < SPI_FRAME_BITS) begin
            next_st.shreg  = {st.shreg[6:0], sda};
            next_st.bitcnt = 5'(st.bitcnt + 1'b1);
            if (st.bitcnt == BYTE_BITS - 5'h01) begin
              next_st.rw       = st.shreg[6];
              next_st.reg_addr = {1'b0, st.shreg[5:0], sda};
              next_st.reg_rd   = st.shreg[6];
            end
            if (st.bitcnt == SPI_FRAME_BITS - 5'h01 && !st.rw) begin
              next_st.reg_wdata = {st.shreg[6:0], sda};
              next_st.reg_wr    = 1'b1;
            end
          end else if (fall && st.rw && st.bitcnt > BYTE_BITS) begin
            next_st.miso = st.shreg[7];
          end
        end
        ST_ADDR: begin
          if (rise) begin
            next_st.shreg  = {st.shreg[6:0], sda};
            next_st.bitcnt = 5'(st.bitcnt + 1'b1);
            if (st.bitcnt == BYTE_BITS - 5'h01) begin
              next_st.rw    = sda;
              next_st.state = (st.shreg[6:0] == smb_addr(st.addr_idx)) ? ST_ACK : ST_IDLE;
            end
          end
        end
        ST_ACK: begin
          if (fall) begin
            if (!st.sda_oe) begin
              next_st.sda_oe = 1'b1;
            end else begin
              next_st.sda_oe = 1'b0;
              next_st.bitcnt = 5'h00;
              if (st.bump) begin
                next_st.reg_addr = 8'(st.reg_addr + 1'b1);
                next_st.bump     = 1'b0;
              end
              if (st.rw) begin
                next_st.state       = ST_RBYTE;
                next_st.reg_rd      = 1'b1;
                next_st.first_drive = 1'b1;
              end else begin
                next_st.state = ST_WBYTE;
              end
            end
          end
        end
        ST_WBYTE: begin
          if (rise) begin
            next_st.shreg  = {st.shreg[6:0], sda};
            next_st.bitcnt = 5'(st.bitcnt + 1'b1);
            if (st.bitcnt == BYTE_BITS - 5'h01) begin
              next_st.state = ST_ACK;
              if (st.have_ptr) begin
                next_st.reg_wdata = {st.shreg[6:0], sda};
                next_st.reg_wr    = 1'b1;
                next_st.bump      = 1'b1;
              end else begin
                next_st.reg_addr = {st.shreg[6:0], sda};
                next_st.have_ptr = 1'b1;
              end
            end
          end
        end
        ST_RBYTE: begin
          if (rise) begin
            next_st.bitcnt = 5'(st.bitcnt + 1'b1);
          end else if (fall) begin
            if (st.bitcnt == BYTE_BITS) begin
              next_st.sda_oe = 1'b0;
              next_st.state  = ST_RACK;
            end else begin
              next_st.sda_oe = ~st.shreg[7];
              next_st.shreg  = {st.shreg[6:0], 1'b0};
            end
          end
        end
        ST_RACK: begin
          if (rise) begin
            if (!sda) begin
              next_st.reg_addr = 8'(st.reg_addr + 1'b1);
              next_st.reg_rd   = 1'b1;
              next_st.bitcnt   = 5'h00;
              next_st.state    = ST_RBYTE;
            end else begin
              next_st.state = ST_IDLE;
            end
          end
        end
        default: next_st.state = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st <= REGS_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign pin13_out             = 1'b0;
  assign pin13_oe              = st.sda_oe & (st.iface == IF_SMB);
  assign pin28_out             = st.miso;
  assign pin28_oe              = (st.state == ST_SPI);
  assign pin29_out             = 1'b0;
  assign pin29_oe              = 1'b0;
  assign lock_out              = 1'b0;
  assign lock_oe               = st.lock_oe;
  assign bidir_coax_port_swing = st.swing;
  assign aux_coax_driver_swing = st.swing;
  assign power_down            = st.power_down;
  assign spi_active            = (st.iface == IF_SPI);
  assign smbus_active          = (st.iface == IF_SMB);
  assign bus_address           = smb_addr(st.addr_idx);
  assign reg_addr              = st.reg_addr;
  assign reg_wdata             = st.reg_wdata;
  assign reg_wr                = st.reg_wr;
  assign reg_rd                = st.reg_rd;

endmodule

/* rtl/cps_pkg.sv */
// constants and types for the control port and status pin block
package cps_pkg;

  // ----------------------------------------------------------------
  // clock and strap settling
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 10;
  localparam int STRAP_WAIT_NS  = 100;
  localparam int STRAP_WAIT_CYC = (STRAP_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W          = 8;

  // ----------------------------------------------------------------
  // four-level pin decode (3-bit thermometer from the pad comparators)
  // ----------------------------------------------------------------
  localparam int          THERM_W  = 3;
  localparam logic [1:0]  LVL_L    = 2'h0;   // tied low through resistor
  localparam logic [1:0]  LVL_R    = 2'h1;   // weak low
  localparam logic [1:0]  LVL_F    = 2'h2;   // floating
  localparam logic [1:0]  LVL_H    = 2'h3;   // tied high

  // ----------------------------------------------------------------
  // positions in the synchronised pin vector
  // ----------------------------------------------------------------
  localparam int P_SWING   = 0;
  localparam int P_MODE    = 3;
  localparam int P_P11LVL  = 6;
  localparam int P_P28LVL  = 9;
  localparam int P_EN      = 12;
  localparam int P_EN_DRV  = 13;
  localparam int P_P11     = 14;
  localparam int P_P11_DRV = 15;
  localparam int P_P13     = 16;
  localparam int P_P29     = 17;
  localparam int PIN_W     = 18;

  // ----------------------------------------------------------------
  // lock pin function codes
  // ----------------------------------------------------------------
  localparam logic [1:0] LOCK_FN_LOCK    = 2'h0;
  localparam logic [1:0] LOCK_FN_CARRIER = 2'h1;
  localparam logic [1:0] LOCK_FN_IRQ     = 2'h2;

  // ----------------------------------------------------------------
  // serial framing
  // ----------------------------------------------------------------
  localparam logic [4:0] BYTE_BITS      = 5'h08;
  localparam logic [4:0] SPI_FRAME_BITS = 5'h10;
  localparam logic [6:0] SMB_ADDR_BASE  = 7'h30;

  typedef enum logic [2:0] {
    IF_NONE = 3'b001,
    IF_SPI  = 3'b010,
    IF_SMB  = 3'b100
  } cps_iface_t;

  typedef enum logic [6:0] {
    ST_IDLE  = 7'b0000001,
    ST_SPI   = 7'b0000010,
    ST_ADDR  = 7'b0000100,
    ST_ACK   = 7'b0001000,
    ST_WBYTE = 7'b0010000,
    ST_RBYTE = 7'b0100000,
    ST_RACK  = 7'b1000000
  } cps_state_t;

endpackage

/* verification/cps_ctrl_pins_monitor.sv */
// concurrent checks on the control port pins, bound to the design top
`timescale 1ns/100ps
module cps_ctrl_pins_monitor
  import cps_pkg::*;
(
  input wire logic       clock,
  input wire logic       rst,
  input wire logic       enable_pin,
  input wire logic       enable_driven,
  input wire logic       pin11_in,
  input wire logic       pin11_driven,
  input wire logic       pin13_out,
  input wire logic       pin13_oe,
  input wire logic       pin28_oe,
  input wire logic       pin29_out,
  input wire logic       pin29_oe,
  input wire logic       reclock_locked,
  input wire logic       carrier_present,
  input wire logic       irq_pending,
  input wire logic [1:0] lock_pin_func,
  input wire logic       lock_out,
  input wire logic       lock_oe,
  input wire logic [1:0] bidir_coax_port_swing,
  input wire logic [1:0] aux_coax_driver_swing,
  input wire logic       power_down,
  input wire logic       spi_active,
  input wire logic       smbus_active,
  input wire logic       reg_wr,
  input wire logic       reg_rd
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  logic       lock_src;
  logic       pd_ref;
  logic [2:0] pd_age;
  assign lock_src = (lock_pin_func == LOCK_FN_CARRIER) ? carrier_present :
                    (lock_pin_func == LOCK_FN_IRQ) ? irq_pending : reclock_locked;
  // age of the enable level, so the sync latency is not mistaken for a fault
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pd_ref <= 1'b0;
      pd_age <= 3'h0;
    end else begin
      pd_ref <= enable_driven && !enable_pin;
      if ((enable_driven && !enable_pin) != pd_ref) pd_age <= 3'h0;
      else if (pd_age != 3'h7) pd_age <= pd_age + 3'h1;
    end
  end
  AST_ONE_IF: assert property (!(spi_active && smbus_active))
    else $error("both serial ports enabled");
  AST_IF_HOLD: assert property (!$past(rst) && $past(spi_active) |-> spi_active)
    else $error("interface selection changed after power-up");
  AST_SWING_PAIR: assert property (bidir_coax_port_swing == aux_coax_driver_swing)
    else $error("drivers got different swings");
  AST_LOCK_SRC: assert property (!$past(rst) && $stable(lock_pin_func)
    |-> lock_oe == $past(lock_src))
    else $error("lock pin does not follow its source");
  AST_LOCK_OD: assert property (lock_out == 1'b0)
    else $error("lock pin driven high");
  AST_PD: assert property (pd_age >= 3'h4 |-> power_down == pd_ref)
    else $error("power down does not follow enable");
  AST_MISO_OE: assert property (!spi_active |-> !pin28_oe)
    else $error("strap pin driven outside spi mode");
  AST_SPI_DESEL: assert property ((spi_active && (pin11_in || !pin11_driven)) [*4]
    |-> !reg_wr && !reg_rd)
    else $error("register access while deselected");
  AST_SCL_FREE: assert property (!pin29_oe)
    else $error("clock pin driven by target");
  AST_OD_LOW: assert property (!pin13_out && !pin29_out)
    else $error("open-drain pin driven high");
  AST_SDA_SMB: assert property (!smbus_active |-> !pin13_oe)
    else $error("data pin pulled outside smbus mode");
endmodule
bind cps_ctrl_pins cps_ctrl_pins_monitor i_cps_ctrl_pins_monitor (
  .clock(clock), .rst(rst), .enable_pin(enable_pin), .enable_driven(enable_driven),
  .pin11_in(pin11_in), .pin11_driven(pin11_driven), .pin13_out(pin13_out),
  .pin13_oe(pin13_oe), .pin28_oe(pin28_oe), .pin29_out(pin29_out),
  .pin29_oe(pin29_oe), .reclock_locked(reclock_locked), .carrier_present(carrier_present),
  .irq_pending(irq_pending), .lock_pin_func(lock_pin_func), .lock_out(lock_out),
  .lock_oe(lock_oe), .bidir_coax_port_swing(bidir_coax_port_swing),
  .aux_coax_driver_swing(aux_coax_driver_swing), .power_down(power_down),
  .spi_active(spi_active), .smbus_active(smbus_active), .reg_wr(reg_wr), .reg_rd(reg_rd));

/* verification/cps_spi_host.sv */
// behavioural spi host: mode 0, 16-bit frames, clock still between frames
`timescale 1ns/100ps
module cps_spi_host (
  output logic      sel_n,
  output logic      sck,
  output logic      mosi,
  input  wire logic miso,
  input  wire logic sda_bus
);
  initial begin
    sel_n = 1'b1;
    sck   = 1'b0;
    mosi  = 1'b0;
  end
  task automatic frame(input logic [15:0] cmd, output logic [7:0] rd);
    rd = 8'h00;
    #3.3 sel_n = 1'b0;
    #100;
    for (int i = 15; i >= 0; i--) begin
      mosi = cmd[i];
      #62.5 sck = 1'b1;
      rd = {rd[6:0], miso};
      #62.5 sck = 1'b0;
    end
    #100 sel_n = 1'b1;
    // released data line shows the opposite level, not a stale copy
    mosi = ~mosi;
    // select must stay high long enough for the target to see the frame end
    #200;
  endtask
  // smbus side: sck doubles as scl, mosi as the host's sda pull-down (1 = released)
  task automatic smb_start();
    #20 mosi = 1'b1;
    #42.5 sck = 1'b1;
    #62.5 mosi = 1'b0;
    #62.5 sck = 1'b0;
  endtask
  task automatic smb_stop();
    #20 mosi = 1'b0;
    #42.5 sck = 1'b1;
    #62.5 mosi = 1'b1;
    #62.5;
  endtask
  // data moves only while scl is low, so no false start or stop is seen
  task automatic smb_write(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      #20 mosi = b[i];
      #42.5 sck = 1'b1;
      #62.5 sck = 1'b0;
    end
    #20 mosi = 1'b1;
    #42.5 sck = 1'b1;
    #50 ack = ~sda_bus;
    #12.5 sck = 1'b0;
  endtask
  // bits taken late in the high phase, then ack (0) or nack (1) from the host
  task automatic smb_read(input logic nack, output logic [7:0] b);
    b = 8'h00;
    for (int i = 0; i < 8; i++) begin
      #62.5 sck = 1'b1;
      #50 b = {b[6:0], sda_bus};
      #12.5 sck = 1'b0;
    end
    #20 mosi = nack;
    #42.5 sck = 1'b1;
    #62.5 sck = 1'b0;
  endtask
endmodule

/* verification/test_control_port_and_status_pins.sv */
// self-checking bench for the control port and status pin block
`timescale 1ns/100ps
module test_control_port_and_status_pins;
  import cps_pkg::*;
  logic             clock = 1'b0;
  logic             rst = 1'b1;
  logic [2:0]       swing, mode, p11l, p28l;
  logic             en_pin, en_drv, p11_drv, locked, carrier, irq;
  logic [1:0]       func;
  logic             sel_n, sck, mosi, miso;
  logic             p13_oe, p13_out, p28_out, p28_oe, p29_out, p29_oe, lock_out, lock_oe;
  logic [1:0]       sw_a, sw_b;
  logic             pd, spi_act, smb_act, reg_wr, reg_rd;
  logic [6:0]       bus_address;
  logic [7:0]       reg_addr, reg_wdata, rd, rd_a, wa, wd;
  logic [7:0]       reg_rdata_w;
  logic             sda_line, ack;
  int               n_mismatch = 0;
  int               compares = 0;
  int               nwr = 0;
  int               n;
  logic [15:0]      r;
  logic             lk;
  // row: mode lo hi swing | en_driven en func | 0 locked carrier irq (levels 0..3)
  logic [15:0] rows [8] = '{16'h8004, 16'h1992, 16'h3ee1, 16'h03c3,
                            16'h64b4, 16'hc1d5, 16'ha6e6, 16'h2f40};
  initial forever #5 clock = ~clock;
  initial begin
    {swing, mode, p11l, p28l} = 12'h0;
    {en_pin, en_drv, p11_drv, locked, carrier, irq, func} = 8'h34;
  end
  assign miso = p28_oe ? p28_out : ~p28_out;
  assign reg_rdata_w = reg_addr ^ 8'ha5;
  // open-drain data line: low while either side pulls it down
  assign sda_line = mosi & ~p13_oe;
  cps_spi_host i_cps_spi_host (.sel_n(sel_n), .sck(sck), .mosi(mosi), .miso(miso),
                               .sda_bus(sda_line));
  cps_ctrl_pins i_cps_ctrl_pins (
    .clock(clock), .rst(rst), .cable_drive_swing_select(swing), .mode_select_level(mode),
    .enable_pin(en_pin), .enable_driven(en_drv), .pin11_level(p11l),
    .pin11_in(p11_drv ? sel_n : ~sel_n), .pin11_driven(p11_drv),
    .pin13_in(sda_line), .pin13_out(p13_out), .pin13_oe(p13_oe),
    .pin28_level(p28l), .pin28_out(p28_out), .pin28_oe(p28_oe), .pin29_in(sck),
    .pin29_out(p29_out), .pin29_oe(p29_oe), .reclock_locked(locked),
    .carrier_present(carrier), .irq_pending(irq), .lock_pin_func(func),
    .lock_out(lock_out), .lock_oe(lock_oe), .bidir_coax_port_swing(sw_a),
    .aux_coax_driver_swing(sw_b), .power_down(pd), .spi_active(spi_act),
    .smbus_active(smb_act), .bus_address(bus_address), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata_w));
  always @(posedge clock) begin
    if (reg_rd) rd_a <= reg_addr;
    if (reg_wr) begin
      wa <= reg_addr;
      wd <= reg_wdata;
      nwr <= nwr + 1;
    end
  end
  function automatic logic [2:0] th(input logic [1:0] l);
    th = (3'h1 << l) - 3'h1;
  endfunction
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic boot(input logic [15:0] v);
    @(posedge clock);
    rst <= 1'b1;
    mode <= th(v[15:14]);
    p11l <= th(v[13:12]);
    p28l <= th(v[11:10]);
    swing <= th(v[9:8]);
    {en_drv, en_pin, func} <= v[7:4];
    {locked, carrier, irq} <= v[2:0];
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    repeat (16) @(posedge clock);
    #1;
  endtask
  task automatic summarize();
    if (n_mismatch == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #50000;
    n_mismatch++;
    summarize();
  end
  initial begin
    repeat (2) @(posedge clock);
    #1;
    chk("outputs in reset", 8'h0, {spi_act, smb_act, pd, lock_oe});
    for (int i = 0; i < 8; i++) begin
      r = rows[i];
      boot(r);
      lk = (r[5:4] == LOCK_FN_CARRIER) ? r[1] : (r[5:4] == LOCK_FN_IRQ) ? r[0] : r[2];
      chk("spi_active", r[15:14] == LVL_F, spi_act);
      chk("smbus_active", r[15:14] == LVL_L, smb_act);
      chk("main swing", r[9:8], sw_a);
      chk("aux swing", r[9:8], sw_b);
      chk("power_down", r[7] & ~r[6], pd);
      chk("lock_oe", lk, lock_oe);
      if (r[15:14] == LVL_L) chk("bus_address", SMB_ADDR_BASE + {r[11:10], r[13:12]},
                                 bus_address);
    end
    boot(16'h80c0);
    i_cps_spi_host.frame({1'b1, 7'h15, 8'h00}, rd);
    chk("read address", 8'h15, rd_a);
    chk("miso byte", 8'h15 ^ 8'ha5, rd);
    i_cps_spi_host.frame({1'b0, 7'h2a, 8'h3c}, rd);
    chk("write address", 8'h2a, wa);
    chk("write data", 8'h3c, wd);
    n = nwr;
    @(posedge clock);
    p11_drv <= 1'b0;
    i_cps_spi_host.frame({1'b0, 7'h11, 8'h77}, rd);
    @(posedge clock);
    p11_drv <= 1'b1;
    chk("writes with select undriven", n[7:0], nwr[7:0]);
    boot(16'h18c0);
    i_cps_spi_host.frame({1'b0, 7'h11, 8'h77}, rd);
    repeat (4) @(posedge clock);
    chk("spi writes in smbus mode", n[7:0], nwr[7:0]);
    // straps lo=1 hi=2 give address index 9
    i_cps_spi_host.smb_start();
    i_cps_spi_host.smb_write({SMB_ADDR_BASE + 7'h09, 1'b0}, ack);
    chk("address ack", 8'h01, ack);
    i_cps_spi_host.smb_write(8'h21, ack);
    chk("pointer ack", 8'h01, ack);
    i_cps_spi_host.smb_write(8'h5a, ack);
    i_cps_spi_host.smb_stop();
    chk("smbus write address", 8'h21, wa);
    chk("smbus write data", 8'h5a, wd);
    i_cps_spi_host.smb_start();
    i_cps_spi_host.smb_write({SMB_ADDR_BASE + 7'h09, 1'b1}, ack);
    i_cps_spi_host.smb_read(1'b1, rd);
    i_cps_spi_host.smb_stop();
    chk("smbus read address", 8'h22, rd_a);
    chk("smbus read byte", 8'h22 ^ 8'ha5, rd);
    i_cps_spi_host.smb_start();
    i_cps_spi_host.smb_write({SMB_ADDR_BASE + 7'h0a, 1'b0}, ack);
    i_cps_spi_host.smb_stop();
    chk("foreign address ack", 8'h00, ack);
    summarize();
  end
endmodule
